//--- nibx_expander.sv
// Four-port nibble I/O expander driven by a host transfer strobe and chip select.
// Notes on behaviour
// - Falling strobe edge captures operation code and port address from the nibble bus.
// - Low two bus bits choose port a, b, c or d.
// - Upper two bus bits choose read, direct write, OR-merge or AND-merge.
// - Direct write replaces the port's stored value.
// - OR-merge stores and drives new nibble OR previous value.
// - AND-merge stores and drives new nibble AND previous value.
// - Rising strobe edge of a write takes bus nibble as data operand.
// - Written result is latched until next write to that port, and driven until a read of that port.
// - Decoded read releases selected port drivers and samples its pins.
// - During a read, selected port pins drive the nibble bus before rising edge.
// - Rising edge ends read; port stays released, nibble bus returns to input.
// - Chip select high: strobe ignored, no output or state change.
// - After reset all ports released and nibble bus input, whatever strobe level.
// - First falling strobe edge leaves the power-on state.
`timescale 1ns/100ps
`default_nettype none
module nibx_expander
   import nibx_pkg::*;
#(
   parameter int PORTS = nibx_pkg::NUM_PORTS
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic transfer_strobe,
   input wire logic chip_select_n,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] nibble_bus_in,
   output nibx_pkg::nibx_pin_drive_t nibble_bus_drv,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] expansion_port_a_in,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] expansion_port_b_in,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] expansion_port_c_in,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] expansion_port_d_in,
   output nibx_pkg::nibx_pin_drive_t expansion_port_a_drv,
   output nibx_pkg::nibx_pin_drive_t expansion_port_b_drv,
   output nibx_pkg::nibx_pin_drive_t expansion_port_c_drv,
   output nibx_pkg::nibx_pin_drive_t expansion_port_d_drv,
   output logic power_on_mode
);
   import nibx_pkg::*;

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   localparam int SYNC_W = 2 + NIBBLE_W * (1 + PORTS);
   logic [SYNC_W-1:0] sync_out;
   logic strobe_s;
   logic cs_n_s;
   logic [NIBBLE_W-1:0] bus_s;
   logic [NIBBLE_W-1:0] pin_s [NUM_PORTS];

   nibx_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in({transfer_strobe, chip_select_n, nibble_bus_in, expansion_port_d_in,
                 expansion_port_c_in, expansion_port_b_in, expansion_port_a_in}),
      .sync_out(sync_out)
   );

   assign strobe_s = sync_out[SYNC_W-1];
   assign cs_n_s = sync_out[SYNC_W-2];
   assign bus_s = sync_out[SYNC_W-3 -: NIBBLE_W];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_pin
         assign pin_s[gi] = sync_out[gi*NIBBLE_W +: NIBBLE_W];
      end
   endgenerate

   // ****************************************************************
   // Strobe edge detection
   // ****************************************************************
   logic strobe_d_r;
   logic fall;
   logic rise;
   logic [2:0] fill_r;
   logic edges_ok;

   // Edges count only once the synchroniser and the delay flop hold real pin
   // levels; a strobe held low through reset is then not taken for a falling edge.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         fill_r <= 3'h0;
      end else begin
         fill_r <= {fill_r[1:0], 1'b1};
      end
   end

   assign edges_ok = fill_r[2];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         strobe_d_r <= 1'b1;
      end else begin
         strobe_d_r <= strobe_s;
      end
   end

   // Chip select gates both edges so a deselected device sees no activity.
   assign fall = edges_ok && strobe_d_r && !strobe_s && !cs_n_s;
   assign rise = edges_ok && !strobe_d_r && strobe_s && !cs_n_s;

   // ****************************************************************
   // Transfer sequencing
   // ****************************************************************
   nibx_state_t state_r;
   nibx_cmd_t cmd_r;
   logic reading;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r <= NIBX_ST_POWER_ON;
      end else begin
         unique case (state_r)
            NIBX_ST_POWER_ON: begin
               if (fall) begin
                  state_r <= NIBX_ST_BUSY;
               end
            end
            NIBX_ST_IDLE: begin
               if (fall) begin
                  state_r <= NIBX_ST_BUSY;
               end
            end
            NIBX_ST_BUSY: begin
               if (rise) begin
                  state_r <= NIBX_ST_IDLE;
               end
            end
            default: begin
               state_r <= NIBX_ST_POWER_ON;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cmd_r <= '0;
      end else if (fall) begin
         cmd_r.op <= nibx_op_t'(bus_s[OP_LSB +: 2]);
         cmd_r.port_sel <= bus_s[PORT_SEL_LSB +: PORT_SEL_W];
      end
   end

   assign reading = (state_r == NIBX_ST_BUSY) && (cmd_r.op == NIBX_OP_READ);
   assign power_on_mode = (state_r == NIBX_ST_POWER_ON);

   // ****************************************************************
   // Port latches and drivers
   // ****************************************************************
   logic [NIBBLE_W-1:0] latch_r [NUM_PORTS];
   logic [NUM_PORTS-1:0] drive_en_r;
   nibx_pin_drive_t port_drv [NUM_PORTS];

   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         logic sel;
         logic wr_now;
         assign sel = (cmd_r.port_sel == PORT_SEL_W'(gi));
         assign wr_now = rise && (state_r == NIBX_ST_BUSY) && sel &&
                         (cmd_r.op != NIBX_OP_READ);

         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               latch_r[gi] <= LATCH_RST;
            end else if (wr_now) begin
               unique case (cmd_r.op)
                  NIBX_OP_DIRECT_WRITE: latch_r[gi] <= bus_s;
                  NIBX_OP_OR_MERGE_WRITE: latch_r[gi] <= latch_r[gi] | bus_s;
                  NIBX_OP_AND_MERGE_WRITE: latch_r[gi] <= latch_r[gi] & bus_s;
                  NIBX_OP_READ: latch_r[gi] <= latch_r[gi];
               endcase
            end
         end

         // Drivers turn off as soon as a read to this port is decoded and stay off until the next write to it.
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               drive_en_r[gi] <= 1'b0;
            end else if (wr_now) begin
               drive_en_r[gi] <= 1'b1;
            end else if (fall && bus_s[OP_LSB +: 2] == NIBX_OP_READ &&
                         bus_s[PORT_SEL_LSB +: PORT_SEL_W] == PORT_SEL_W'(gi)) begin
               drive_en_r[gi] <= 1'b0;
            end
         end

         assign port_drv[gi].dout = latch_r[gi];
         assign port_drv[gi].oe = {NIBBLE_W{drive_en_r[gi]}};
      end
   endgenerate

   assign expansion_port_a_drv = port_drv[0];
   assign expansion_port_b_drv = port_drv[1];
   assign expansion_port_c_drv = port_drv[2];
   assign expansion_port_d_drv = port_drv[3];

   // ****************************************************************
   // Nibble bus read-back
   // ****************************************************************
   // Pin data lags the pins by the synchroniser depth; the host's long
   // strobe low time leaves ample margin before the rising edge.
   logic [NIBBLE_W-1:0] rd_data_r;
   logic rd_oe_r;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_data_r <= '0;
      end else if (reading) begin
         rd_data_r <= pin_s[cmd_r.port_sel];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_oe_r <= 1'b0;
      end else if (rise) begin
         rd_oe_r <= 1'b0;
      end else begin
         rd_oe_r <= reading;
      end
   end

   assign nibble_bus_drv.dout = rd_data_r;
   assign nibble_bus_drv.oe = {NIBBLE_W{rd_oe_r}};

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_fall_seen;
      fall;
   endsequence

   property p_power_on_oe;
      @(posedge ref_clk) disable iff (!reset_n)
      power_on_mode |-> (drive_en_r == '0 && !rd_oe_r);
   endproperty
   a_power_on_oe: assert property (p_power_on_oe) else $error("drive during power-on");

   property p_exit_power_on;
      @(posedge ref_clk) disable iff (!reset_n)
      (power_on_mode && fall) |=> !power_on_mode;
   endproperty
   a_exit_power_on: assert property (p_exit_power_on) else $error("power-on not left");

   property p_capture;
      @(posedge ref_clk) disable iff (!reset_n)
      s_fall_seen |=> (cmd_r.port_sel == $past(bus_s[1:0]) && cmd_r.op == $past(bus_s[3:2]));
   endproperty
   a_capture: assert property (p_capture) else $error("command not captured");

   property p_cs_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      cs_n_s |=> ($stable(cmd_r) && $stable(state_r) && $stable(latch_r[0]));
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("state changed while deselected");

   property p_direct;
      @(posedge ref_clk) disable iff (!reset_n)
      (rise && state_r == NIBX_ST_BUSY && cmd_r.op == NIBX_OP_DIRECT_WRITE
       && cmd_r.port_sel == 2'h0) |=> (latch_r[0] == $past(bus_s) && drive_en_r[0]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct write wrong");

   property p_or;
      @(posedge ref_clk) disable iff (!reset_n)
      (rise && state_r == NIBX_ST_BUSY && cmd_r.op == NIBX_OP_OR_MERGE_WRITE
       && cmd_r.port_sel == 2'h1) |=> (latch_r[1] == ($past(bus_s) | $past(latch_r[1])));
   endproperty
   a_or: assert property (p_or) else $error("or merge wrong");

   property p_and;
      @(posedge ref_clk) disable iff (!reset_n)
      (rise && state_r == NIBX_ST_BUSY && cmd_r.op == NIBX_OP_AND_MERGE_WRITE
       && cmd_r.port_sel == 2'h2) |=> (latch_r[2] == ($past(bus_s) & $past(latch_r[2])));
   endproperty
   a_and: assert property (p_and) else $error("and merge wrong");

   property p_read_release;
      @(posedge ref_clk) disable iff (!reset_n)
      (fall && bus_s == 4'h3) |=> !drive_en_r[3] ##1 rd_oe_r;
   endproperty
   a_read_release: assert property (p_read_release) else $error("read did not release port");

   property p_read_end;
      @(posedge ref_clk) disable iff (!reset_n)
      (rise && reading) |=> (!rd_oe_r && state_r == NIBX_ST_IDLE);
   endproperty
   a_read_end: assert property (p_read_end) else $error("read did not end");

   property p_read_data;
      @(posedge ref_clk) disable iff (!reset_n)
      reading |=> (rd_data_r == $past(pin_s[cmd_r.port_sel]));
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not from port");
endmodule
`default_nettype wire

//--- nibx_pkg.sv
// Package for the nibble I/O expander: field layouts, op codes, states and timing.
package nibx_pkg;
   localparam int NIBBLE_W = 4;
   localparam int NUM_PORTS = 4;
   localparam int PORT_SEL_W = 2;
   // Field positions inside the command nibble.
   localparam int PORT_SEL_LSB = 0;
   localparam int OP_LSB = 2;
   // Reset values.
   localparam logic [3:0] LATCH_RST = 4'h0;
   // Timing: strobe low time, with its cycle count at 40 MHz.
   localparam int CLK_PERIOD_PS = 25000;
   localparam int STROBE_LOW_MIN_NS = 700;
   localparam int STROBE_LOW_MIN_CYC =
      (STROBE_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      NIBX_OP_READ = 2'h0,
      NIBX_OP_DIRECT_WRITE = 2'h1,
      NIBX_OP_OR_MERGE_WRITE = 2'h2,
      NIBX_OP_AND_MERGE_WRITE = 2'h3
   } nibx_op_t;

   // Sequence: power-on -> busy -> idle -> busy; only the idle/busy steps are Gray.
   typedef enum logic [1:0] {
      NIBX_ST_POWER_ON = 2'h0,
      NIBX_ST_IDLE = 2'h1,
      NIBX_ST_BUSY = 2'h3
   } nibx_state_t;

   typedef struct packed {
      nibx_op_t op;
      logic [PORT_SEL_W-1:0] port_sel;
   } nibx_cmd_t;

   typedef struct packed {
      logic [NIBBLE_W-1:0] dout;
      logic [NIBBLE_W-1:0] oe;
   } nibx_pin_drive_t;
endpackage

//--- nibx_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module nibx_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- nibx_host_model.sv
// Host side of the nibble expander: strobe, select and nibble bus driver.
`timescale 1ns/100ps
`default_nettype none
module nibx_host_model
   import nibx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [nibx_pkg::NIBBLE_W-1:0] bus_level,
   output logic transfer_strobe,
   output logic chip_select_n,
   output logic [nibx_pkg::NIBBLE_W-1:0] bus_dout,
   output logic bus_oe
);
   initial begin
      transfer_strobe = 1'b1;
      chip_select_n = 1'b1;
      bus_dout = 4'h0;
      bus_oe = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_strobe(input logic v);
      step(1);
      transfer_strobe = v;
   endtask

   // Phases are held well past the synchroniser lag of the device.
   task automatic xfer(input logic sel, input nibx_op_t op, input logic [1:0] port,
                       input logic [3:0] data, output logic [3:0] rd);
      step(1);
      chip_select_n = ~sel;
      bus_dout = {op, port};
      bus_oe = 1'b1;
      step(4);
      transfer_strobe = 1'b0;
      step(4);
      bus_dout = data;
      bus_oe = (op != NIBX_OP_READ);
      step(STROBE_LOW_MIN_CYC - 4);
      rd = bus_level;
      transfer_strobe = 1'b1;
      step(5);
      bus_oe = 1'b0;
      chip_select_n = 1'b1;
      step(6);
   endtask

   // The port is read twice and only the second result is kept; the first read already sees the settled pins.
   task automatic read_port(input logic [1:0] port, output logic [3:0] rd);
      xfer(1'b1, NIBX_OP_READ, port, 4'h0, rd);
      xfer(1'b1, NIBX_OP_READ, port, 4'h0, rd);
   endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the nibble I/O expander.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import nibx_pkg::*;
   logic ref_clk;
   logic reset_n;
   logic strobe;
   logic cs_n;
   logic host_oe;
   logic power_on_mode;
   logic [3:0] host_dout;
   logic [3:0] bus_level;
   logic [3:0] rd;
   nibx_pin_drive_t bus_drv;
   nibx_pin_drive_t port_drv [4];
   logic [3:0] port_pin [4];
   logic [3:0] ext [4];
   logic [3:0] exp_latch [4];
   logic exp_oe [4];
   int n_fail;
   int cmp_count;

   // ****************************************
   // Pins and instances
   // ****************************************
   // A released bus shows the inverse of the last host value, so stale data cannot pass.
   for (genvar b = 0; b < 4; b++) begin : g_bit
      assign bus_level[b] = bus_drv.oe[b] ? bus_drv.dout[b] : (host_oe ? host_dout[b] : ~host_dout[b]);
      for (genvar p = 0; p < 4; p++) begin : g_port
         assign port_pin[p][b] = port_drv[p].oe[b] ? port_drv[p].dout[b] : ext[p][b];
      end
   end

   nibx_host_model i_nibx_host_model (.ref_clk(ref_clk), .bus_level(bus_level),
      .transfer_strobe(strobe), .chip_select_n(cs_n), .bus_dout(host_dout), .bus_oe(host_oe));

   nibx_expander i_nibx_expander (.ref_clk(ref_clk), .reset_n(reset_n),
      .transfer_strobe(strobe), .chip_select_n(cs_n), .nibble_bus_in(bus_level),
      .nibble_bus_drv(bus_drv), .expansion_port_a_in(port_pin[0]),
      .expansion_port_b_in(port_pin[1]), .expansion_port_c_in(port_pin[2]),
      .expansion_port_d_in(port_pin[3]), .expansion_port_a_drv(port_drv[0]),
      .expansion_port_b_drv(port_drv[1]), .expansion_port_c_drv(port_drv[2]),
      .expansion_port_d_drv(port_drv[3]), .power_on_mode(power_on_mode));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Checks and scenarios
   // ****************************************
   task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_ports();
      for (int p = 0; p < 4; p++) begin
         chk($sformatf("port %0d latch", p), exp_latch[p], port_drv[p].dout);
         chk($sformatf("port %0d oe", p), {4{exp_oe[p]}}, port_drv[p].oe);
      end
      chk("bus oe", 4'h0, bus_drv.oe);
   endtask

   task automatic do_write(input nibx_op_t op, input logic [1:0] p, input logic [3:0] d);
      i_nibx_host_model.xfer(1'b1, op, p, d, rd);
      case (op)
         NIBX_OP_DIRECT_WRITE: exp_latch[p] = d;
         NIBX_OP_OR_MERGE_WRITE: exp_latch[p] = exp_latch[p] | d;
         default: exp_latch[p] = exp_latch[p] & d;
      endcase
      exp_oe[p] = 1'b1;
   endtask

   task automatic t_power_on();
      chk_ports();
      chk("power on", 4'h1, {3'h0, power_on_mode});
      i_nibx_host_model.set_strobe(1'b1);
      i_nibx_host_model.step(8);
      chk("power on after rise", 4'h1, {3'h0, power_on_mode});
      chk_ports();
   endtask

   task automatic t_writes();
      logic [3:0] vals [4] = '{4'hA, 4'h5, 4'hC, 4'h3};
      for (int p = 0; p < 4; p++) begin
         do_write(NIBX_OP_DIRECT_WRITE, p[1:0], vals[p]);
         if (p == 0) begin
            chk("power on exit", 4'h0, {3'h0, power_on_mode});
         end
      end
      chk_ports();
      for (int p = 0; p < 4; p++) begin
         do_write(NIBX_OP_OR_MERGE_WRITE, p[1:0], 4'h6);
         do_write(NIBX_OP_AND_MERGE_WRITE, p[1:0], 4'hB);
      end
      chk_ports();
      do_write(NIBX_OP_DIRECT_WRITE, 2'h2, 4'h9);
      chk_ports();
   endtask

   task automatic t_cs_high();
      i_nibx_host_model.xfer(1'b0, NIBX_OP_DIRECT_WRITE, 2'h0, 4'h1, rd);
      i_nibx_host_model.xfer(1'b0, NIBX_OP_READ, 2'h3, 4'h0, rd);
      chk_ports();
   endtask

   task automatic t_read();
      ext[1] = 4'h9;
      ext[3] = 4'h4;
      i_nibx_host_model.read_port(2'h1, rd);
      chk("read port 1", 4'h9, rd);
      exp_oe[1] = 1'b0;
      chk_ports();
      i_nibx_host_model.read_port(2'h3, rd);
      chk("read port 3", 4'h4, rd);
      exp_oe[3] = 1'b0;
      chk_ports();
      do_write(NIBX_OP_OR_MERGE_WRITE, 2'h1, 4'h2);
      chk_ports();
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("unexpected timeout expected done seen hang");
      give_verdict();
   end

   initial begin
      reset_n = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      for (int p = 0; p < 4; p++) begin
         ext[p] = 4'h0;
         exp_latch[p] = LATCH_RST;
         exp_oe[p] = 1'b0;
      end
      i_nibx_host_model.set_strobe(1'b0);
      repeat (10) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      i_nibx_host_model.step(4);
      t_power_on();
      t_writes();
      t_cs_high();
      t_read();
      give_verdict();
   end
endmodule
`default_nettype wire
